// [rtl/crs_consts.vh]
// opcode, reset-value and direction-target constants for the rotate/subtract/xor group
// assumes: included by the execution core files and by the verification files
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH
`define CRS_OP_W 4
`define CRS_OP_NOP 4'h0
`define CRS_OP_ROTATE_RIGHT 4'h1
`define CRS_OP_LITERAL_MINUS_ACC 4'h2
`define CRS_OP_FILE_MINUS_ACC 4'h3
`define CRS_OP_FILE_MINUS_ACC_BORROW 4'h4
`define CRS_OP_NIBBLE_SWAP 4'h5
`define CRS_OP_XOR_LITERAL 4'h6
`define CRS_OP_XOR_FILE 4'h7
`define CRS_OP_DIRECTION_LOAD 4'h8
`define CRS_OP_SLEEP 4'h9
`define CRS_DIR_PORT_A 3'h5
`define CRS_DIR_PORT_B 3'h6
`define CRS_DIR_PORT_C 3'h7
`define CRS_ACC_RESET 8'h00
`define CRS_DIR_RESET 8'hff
`define CRS_WDT_CLEAR 8'h00
`define CRS_WDT_W 8
`define CRS_PRESCALE_W 8
`endif

// [rtl/crs_alu.v]
// combinational arithmetic unit: subtract, rotate, swap, xor and flag generation
// assumes: operands stable for the whole instruction cycle
`timescale 1ns/100ps
`default_nettype none
`include "crs_consts.vh"
module crs_alu (
   // operation
   input wire [3:0] op,
   input wire carry_in,
   // operands
   input wire [7:0] acc,
   input wire [7:0] literal,
   input wire [7:0] file_data,
   // result
   output reg [7:0] result,
   output reg carry_out,
   output reg digit_carry_out,
   output wire zero_out
);

   // a - b - borrow, carry out is not-borrow
   function [9:0] sub8;
      input [7:0] a;
      input [7:0] b;
      input borrow;
      reg [8:0] full;
      reg [4:0] low;
      begin
         full = {1'b0, a} - {1'b0, b} - {8'h00, borrow};
         low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow};
         sub8 = {~full[8], ~low[4], full[7:0]};
      end
   endfunction

   reg [9:0] diff;

   always @* begin
      diff = 10'h000;
      result = acc;
      carry_out = carry_in;
      digit_carry_out = 1'b0;
      case (op)
         `CRS_OP_ROTATE_RIGHT: begin
            result = {carry_in, file_data[7:1]};
            carry_out = file_data[0];
         end
         `CRS_OP_LITERAL_MINUS_ACC: begin
            diff = sub8(literal, acc, 1'b0);
            result = diff[7:0];
            carry_out = diff[9];
            digit_carry_out = diff[8];
         end
         `CRS_OP_FILE_MINUS_ACC: begin
            diff = sub8(file_data, acc, 1'b0);
            result = diff[7:0];
            carry_out = diff[9];
            digit_carry_out = diff[8];
         end
         `CRS_OP_FILE_MINUS_ACC_BORROW: begin
            diff = sub8(file_data, acc, ~carry_in);
            result = diff[7:0];
            carry_out = diff[9];
            digit_carry_out = diff[8];
         end
         `CRS_OP_NIBBLE_SWAP: begin
            result = {file_data[3:0], file_data[7:4]};
         end
         `CRS_OP_XOR_LITERAL: begin
            result = acc ^ literal;
         end
         `CRS_OP_XOR_FILE: begin
            result = acc ^ file_data;
         end
         default: begin
            result = acc;
         end
      endcase
   end

   assign zero_out = (result == 8'h00);

endmodule
`default_nettype wire

// [rtl/crs_exec.v]
// execution stage for the rotate/subtract/swap/xor/direction/sleep instruction group
// assumes: decoded instruction presented for one clock with exec_valid; file register
// read data returned combinationally for file_addr in the same cycle
`timescale 1ns/100ps
`default_nettype none
`include "crs_consts.vh"

//////////////////////////////////////////////////////////////////////////////////////////
module crs_exec (
   // clock and reset
   input wire clock,
   input wire resetn,
   // decoded instruction
   input wire exec_valid,
   input wire [3:0] exec_op,
   input wire [7:0] exec_literal,
   input wire [6:0] exec_file_addr,
   input wire exec_dest_file,
   // file register access
   output wire [6:0] file_addr,
   input wire [7:0] file_rdata,
   output reg file_we_q,
   output reg [6:0] file_waddr_q,
   output reg [7:0] file_wdata_q,
   // architectural state
   output reg [7:0] acc_q,
   output reg carry_q,
   output reg digit_carry_q,
   output reg zero_q,
   output reg power_down_flag_q,
   output reg expiry_flag_q,
   // port direction registers
   output reg [7:0] port_a_direction_q,
   output reg [7:0] port_b_direction_q,
   output reg [7:0] port_c_direction_q,
   // watchdog
   input wire watchdog_tick,
   input wire [7:0] prescale_limit,
   output reg [7:0] watchdog_counter_q,
   output reg [7:0] prescale_q,
   // power
   input wire wake,
   output reg sleep_q,
   output wire osc_run
);

   wire [7:0] alu_result;
   wire alu_carry;
   wire alu_dc;
   wire alu_zero;
   wire go;

   //////////////////////////////////////////////////////////////////////////////////////
   // datapath

   // while asleep the core accepts nothing; the fetch side is frozen anyway
   assign go = exec_valid & ~sleep_q;
   assign file_addr = exec_file_addr;
   assign osc_run = ~sleep_q;

   crs_alu u_alu (
      .op(exec_op),
      .carry_in(carry_q),
      .acc(acc_q),
      .literal(exec_literal),
      .file_data(file_rdata),
      .result(alu_result),
      .carry_out(alu_carry),
      .digit_carry_out(alu_dc),
      .zero_out(alu_zero)
   );

   function writes_file_form;
      input [3:0] op;
      begin
         writes_file_form = (op == `CRS_OP_ROTATE_RIGHT) || (op == `CRS_OP_FILE_MINUS_ACC) ||
            (op == `CRS_OP_FILE_MINUS_ACC_BORROW) || (op == `CRS_OP_NIBBLE_SWAP) ||
            (op == `CRS_OP_XOR_FILE);
      end
   endfunction

   function is_sub;
      input [3:0] op;
      begin
         is_sub = (op == `CRS_OP_LITERAL_MINUS_ACC) || (op == `CRS_OP_FILE_MINUS_ACC) ||
            (op == `CRS_OP_FILE_MINUS_ACC_BORROW);
      end
   endfunction

   //////////////////////////////////////////////////////////////////////////////////////
   // state update, one instruction per clock

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         acc_q <= `CRS_ACC_RESET;
         carry_q <= 1'b0;
         digit_carry_q <= 1'b0;
         zero_q <= 1'b0;
         power_down_flag_q <= 1'b1;
         expiry_flag_q <= 1'b1;
         port_a_direction_q <= `CRS_DIR_RESET;
         port_b_direction_q <= `CRS_DIR_RESET;
         port_c_direction_q <= `CRS_DIR_RESET;
         file_we_q <= 1'b0;
         file_waddr_q <= 7'h00;
         file_wdata_q <= 8'h00;
         sleep_q <= 1'b0;
      end else begin
         file_we_q <= 1'b0;
         if (sleep_q && wake) begin
            sleep_q <= 1'b0;
         end
         if (go) begin
            if (writes_file_form(exec_op)) begin
               if (exec_dest_file) begin
                  file_we_q <= 1'b1;
                  file_waddr_q <= exec_file_addr;
                  file_wdata_q <= alu_result;
               end else begin
                  acc_q <= alu_result;
               end
            end
            if ((exec_op == `CRS_OP_LITERAL_MINUS_ACC) || (exec_op == `CRS_OP_XOR_LITERAL)) begin
               acc_q <= alu_result;
            end
            if (is_sub(exec_op)) begin
               carry_q <= alu_carry;
               digit_carry_q <= alu_dc;
               zero_q <= alu_zero;
            end
            if (exec_op == `CRS_OP_ROTATE_RIGHT) begin
               carry_q <= alu_carry;
            end
            if ((exec_op == `CRS_OP_XOR_LITERAL) || (exec_op == `CRS_OP_XOR_FILE)) begin
               zero_q <= alu_zero;
            end
            if (exec_op == `CRS_OP_DIRECTION_LOAD) begin
               case (exec_file_addr[2:0])
                  `CRS_DIR_PORT_A: port_a_direction_q <= acc_q;
                  `CRS_DIR_PORT_B: port_b_direction_q <= acc_q;
                  `CRS_DIR_PORT_C: port_c_direction_q <= acc_q;
                  default: port_a_direction_q <= port_a_direction_q;
               endcase
            end
            if (exec_op == `CRS_OP_SLEEP) begin
               power_down_flag_q <= 1'b0;
               expiry_flag_q <= 1'b1;
               sleep_q <= 1'b1;
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // watchdog: prescaler divides ticks, counter counts prescaler wraps

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         watchdog_counter_q <= `CRS_WDT_CLEAR;
         prescale_q <= 8'h00;
      end else if (go && exec_op == `CRS_OP_SLEEP) begin
         watchdog_counter_q <= `CRS_WDT_CLEAR;
         prescale_q <= 8'h00;
      end else if (watchdog_tick) begin
         if (prescale_q >= prescale_limit) begin
            prescale_q <= 8'h00;
            watchdog_counter_q <= watchdog_counter_q + 8'h01;
         end else begin
            prescale_q <= prescale_q + 8'h01;
         end
      end
   end

endmodule
`default_nettype wire

// [verif/crs_exec_checker.sv]
// concurrent checks on the rotate/subtract/xor execution stage
// assumes: bound to crs_exec and watching its ports only
`timescale 1ns/100ps
`default_nettype none
`include "crs_consts.vh"
module crs_exec_checker (
   // clock and reset
   input wire clock,
   input wire resetn,
   // instruction
   input wire exec_valid,
   input wire exec_dest_file,
   input wire [3:0] exec_op,
   input wire [7:0] exec_literal,
   input wire [7:0] file_rdata,
   input wire [6:0] exec_file_addr,
   // power
   input wire sleep_q,
   input wire osc_run,
   // results
   input wire file_we_q,
   input wire [6:0] file_waddr_q,
   input wire [7:0] file_wdata_q,
   input wire carry_q,
   input wire digit_carry_q,
   input wire zero_q,
   input wire power_down_flag_q,
   input wire expiry_flag_q,
   input wire [7:0] acc_q,
   input wire [7:0] port_a_direction_q
);
////////////////////////////////////////////////////////////
default clocking @(posedge clock); endclocking
default disable iff (!resetn);
// instructions offered while asleep are dropped, so only these count
wire tk = exec_valid && !sleep_q;
a_rot_right: assert property (tk && exec_op == `CRS_OP_ROTATE_RIGHT && !exec_dest_file |=>
   acc_q == {$past(carry_q), $past(file_rdata)} >> 1 && carry_q == $past(file_rdata[0]))
   else $error("rotate result wrong");
a_lit_sub: assert property (tk && exec_op == `CRS_OP_LITERAL_MINUS_ACC |=>
   acc_q == $past(exec_literal) - $past(acc_q) && carry_q == ($past(acc_q) <= $past(exec_literal)))
   else $error("literal subtract wrong");
a_file_dest: assert property (tk && exec_op == `CRS_OP_FILE_MINUS_ACC && exec_dest_file |=>
   file_we_q && file_waddr_q == $past(exec_file_addr)
   && file_wdata_q == $past(file_rdata) - $past(acc_q)) else $error("file write wrong");
a_swap_flags: assert property (tk && exec_op == `CRS_OP_NIBBLE_SWAP |=>
   $stable({carry_q, digit_carry_q, zero_q})) else $error("swap changed flags");
a_xor_zero: assert property (tk && exec_op == `CRS_OP_XOR_LITERAL |=>
   acc_q == ($past(acc_q) ^ $past(exec_literal)) && zero_q == (acc_q == 8'h00)
   && $stable(carry_q)) else $error("xor literal wrong");
a_sleep_flags: assert property (tk && exec_op == `CRS_OP_SLEEP |=>
   !power_down_flag_q && expiry_flag_q && sleep_q) else $error("sleep flags wrong");
a_osc_halt: assert property (sleep_q |-> !osc_run) else $error("oscillator runs asleep");
// an instruction offered while asleep must leave acc_q, carry, zero and the port A direction alone
a_asleep_idle: assert property (exec_valid && sleep_q |=>
   $stable(acc_q) && $stable(port_a_direction_q) && $stable({carry_q, zero_q}))
   else $error("instruction executed asleep");
a_dir_load: assert property (tk && exec_op == `CRS_OP_DIRECTION_LOAD
   && exec_file_addr[2:0] == `CRS_DIR_PORT_A |=> port_a_direction_q == $past(acc_q))
   else $error("direction load wrong");
endmodule
bind crs_exec crs_exec_checker chk (.clock, .resetn, .exec_valid, .exec_dest_file, .sleep_q,
   .osc_run, .exec_op, .exec_literal, .file_rdata, .exec_file_addr, .file_waddr_q, .file_we_q,
   .carry_q, .digit_carry_q, .zero_q, .power_down_flag_q, .expiry_flag_q, .file_wdata_q,
   .acc_q, .port_a_direction_q);
`default_nettype wire

// [verif/crs_exec_test.sv]
// self-checking bench for the execution stage
// assumes: file store replaced by driving file_rdata with each instruction
`timescale 1ns/100ps
`default_nettype none
`include "crs_consts.vh"
`define CHK(a, b) tests_run++; if ((a) !== (b)) begin failures++; \
   $display("wrong value at %0t: %h vs %h", $time, a, b); end
module crs_exec_test;
reg clock = 0, resetn = 0, exec_valid = 0, exec_dest_file = 0, watchdog_tick = 1, wake = 0;
reg [3:0] exec_op = 0;
reg [7:0] exec_literal = 0, file_rdata = 0, prescale_limit = 8'h02, e = 0;
reg [6:0] exec_file_addr = 0, i;
wire [6:0] file_addr, file_waddr_q;
wire [7:0] file_wdata_q, acc_q, port_a_direction_q, port_b_direction_q, port_c_direction_q;
wire [7:0] watchdog_counter_q, prescale_q;
wire file_we_q, carry_q, digit_carry_q, zero_q, power_down_flag_q, expiry_flag_q, sleep_q, osc_run;
integer failures = 0, tests_run = 0;
reg [7:0] dir_e [5:7];
crs_exec uut (.clock, .resetn, .exec_valid, .exec_op, .exec_literal, .exec_file_addr,
   .exec_dest_file, .file_addr, .file_rdata, .file_we_q, .file_waddr_q, .file_wdata_q, .acc_q,
   .carry_q, .digit_carry_q, .zero_q, .power_down_flag_q, .expiry_flag_q, .port_a_direction_q,
   .port_b_direction_q, .port_c_direction_q, .watchdog_tick, .prescale_limit,
   .watchdog_counter_q, .prescale_q, .wake, .sleep_q, .osc_run);
initial forever #50 clock = ~clock;
////////////////////////////////////////////////////////////
task run(input [3:0] op, input [7:0] k, input [6:0] f, input d, input [7:0] rd);
   exec_op = op;
   exec_literal = k;
   exec_file_addr = f;
   exec_dest_file = d;
   file_rdata = rd;
   exec_valid = 1;
   @(posedge clock);
   #1;
endtask
task t_rotate;
   run(`CRS_OP_LITERAL_MINUS_ACC, 8'h05, 0, 0, 0);
   run(`CRS_OP_ROTATE_RIGHT, 0, 7'h10, 0, 8'h81);
   `CHK({acc_q, carry_q}, {8'hc0, 1'b1})
   run(`CRS_OP_ROTATE_RIGHT, 0, 7'h21, 1, 8'h02);
   `CHK({file_we_q, file_waddr_q, file_wdata_q, carry_q, acc_q}, {8'ha1, 9'h102, 8'hc0})
   `CHK(file_addr, 7'h21)
   exec_valid = 0;
   @(posedge clock);
   #1;
   `CHK(file_we_q, 1'b0)
endtask
task t_subtract;
   run(`CRS_OP_LITERAL_MINUS_ACC, 8'h30, 0, 0, 0);
   `CHK({acc_q, carry_q, digit_carry_q, zero_q}, {8'h70, 3'b010})
   run(`CRS_OP_LITERAL_MINUS_ACC, 8'h70, 0, 0, 0);
   `CHK({acc_q, carry_q, digit_carry_q, zero_q}, {8'h00, 3'b111})
   run(`CRS_OP_XOR_LITERAL, 8'h13, 0, 0, 0);
   run(`CRS_OP_FILE_MINUS_ACC, 0, 7'h22, 1, 8'h22);
   `CHK({file_wdata_q, acc_q, carry_q, digit_carry_q, zero_q}, {16'h0f13, 3'b100})
   run(`CRS_OP_FILE_MINUS_ACC_BORROW, 0, 7'h22, 0, 8'h13);
   `CHK({acc_q, carry_q, digit_carry_q, zero_q}, {8'h00, 3'b111})
   run(`CRS_OP_XOR_LITERAL, 8'h01, 0, 0, 0);
   run(`CRS_OP_FILE_MINUS_ACC, 0, 7'h22, 0, 8'h00);
   `CHK({acc_q, carry_q, digit_carry_q, zero_q}, {8'hff, 3'b000})
   // carry now clear, so the borrow form takes one more away
   run(`CRS_OP_FILE_MINUS_ACC_BORROW, 0, 7'h22, 0, 8'h05);
   `CHK({acc_q, carry_q, digit_carry_q, zero_q}, {8'h05, 3'b000})
endtask
task t_swap_xor;
   run(`CRS_OP_LITERAL_MINUS_ACC, 8'h05, 0, 0, 0);
   run(`CRS_OP_NIBBLE_SWAP, 0, 7'h30, 0, 8'ha5);
   `CHK({acc_q, carry_q, digit_carry_q, zero_q}, {8'h5a, 3'b111})
   run(`CRS_OP_XOR_FILE, 0, 7'h30, 1, 8'h0f);
   `CHK({file_wdata_q, acc_q, carry_q, zero_q}, {16'h555a, 2'b10})
   run(`CRS_OP_XOR_LITERAL, 8'h5a, 0, 0, 0);
   `CHK({acc_q, carry_q, digit_carry_q, zero_q}, {8'h00, 3'b111})
endtask
task t_direction;
   for (i = 4; i < 8; i++) begin
      run(`CRS_OP_XOR_LITERAL, {1'b0, i}, 0, 0, 0);
      e = e ^ {1'b0, i};
      run(`CRS_OP_DIRECTION_LOAD, 0, i, 0, 0);
      if (i > 4) dir_e[i] = e;
      `CHK({port_a_direction_q, port_b_direction_q, port_c_direction_q}, {dir_e[5], dir_e[6], dir_e[7]})
   end
endtask
task t_sleep;
   `CHK({power_down_flag_q, expiry_flag_q}, 2'b11)
   run(`CRS_OP_SLEEP, 0, 0, 0, 0);
   `CHK({power_down_flag_q, expiry_flag_q}, 2'b01)
   `CHK({watchdog_counter_q, prescale_q}, 16'h0000)
   `CHK({sleep_q, osc_run}, 2'b10)
   run(`CRS_OP_XOR_LITERAL, 8'hff, 0, 0, 0);
   `CHK(acc_q, 8'h00)
   exec_valid = 0;
   wake = 1;
   @(posedge clock);
   #1;
   wake = 0;
   `CHK({sleep_q, osc_run}, 2'b01)
endtask
task conclude;
   $display("failures=%0d tests_run=%0d", failures, tests_run);
   if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
   else $display("CHECKS NOT OK");
   $finish;
endtask
initial begin
   dir_e[5] = 8'hff;
   dir_e[6] = 8'hff;
   dir_e[7] = 8'hff;
   repeat (3) @(posedge clock);
   #1;
   resetn = 1;
   t_rotate;
   t_subtract;
   t_swap_xor;
   t_direction;
   t_sleep;
   conclude;
end
// whole sequence is about 30 cycles; this leaves ample margin
initial begin
   #20000;
   failures++;
   conclude;
end
endmodule
`default_nettype wire
